// *** common/prspi_defines.svh ***
/*
 Constants of the pressure readout serial target: widths, stream framing and timing counts.
 Assumes the core clock period given here matches the clock that drives the block.
*/
// What this block does
// - Every 15-bit value leaves as a 16-bit word, MSB zero.
// - Effective resolution 15, 14 or 12 bits.
// - MISO holds 200 ns after sample edge.
// - Clock mode zero: idle low, rising samples.
// - Dummy byte, then repeated MSB-first pressure words.
`ifndef PRSPI_DEFINES_SVH
`define PRSPI_DEFINES_SVH

`define PRSPI_WORD_BITS        15
`define PRSPI_XFER_BITS        16
`define PRSPI_DUMMY_BITS       8
`define PRSPI_DUMMY_BYTE       8'hFF
`define PRSPI_EFF_BITS         15
`define PRSPI_FIFO_DEPTH       32

`define PRSPI_CLK_PERIOD_PS    25000
`define PRSPI_HOLD_NS          200
`define PRSPI_HOLD_CYC         ((`PRSPI_HOLD_NS * 1000 + `PRSPI_CLK_PERIOD_PS - 1) / `PRSPI_CLK_PERIOD_PS)
`define PRSPI_SEL_SETUP_NS     10
`define PRSPI_SCK_MAX_KHZ      640
`define PRSPI_SCK_MAX_SPEC_KHZ 730

`endif

// *** common/prspi_pkg.sv ***
/*
 Types shared by the pressure readout target and its bench.
 Assumes prspi_defines.svh is on the include path.
*/
`include "prspi_defines.svh"

package prspi_pkg;
   typedef logic [`PRSPI_WORD_BITS-1:0] prspi_word_t;
   typedef logic [`PRSPI_XFER_BITS-1:0] prspi_xfer_t;

   typedef enum logic [1:0] {
      PRSPI_IDLE,
      PRSPI_PREAMBLE,
      PRSPI_WORD
   } prspi_state_e;
endpackage : prspi_pkg

// *** common/prspi_fifo_if.sv ***
/*
 Valid/ready carrier between the readout logic and its word buffer.
 Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps

interface prspi_fifo_if #(parameter int P_WIDTH = 15);
   logic               wr_valid;
   logic               wr_ready;
   logic [P_WIDTH-1:0] wr_data;
   logic               rd_valid;
   logic               rd_ready;
   logic [P_WIDTH-1:0] rd_data;

   modport fifo_mp (input wr_valid, input wr_data, output wr_ready,
                    output rd_valid, output rd_data, input rd_ready);
   modport user_mp (output wr_valid, output wr_data, input wr_ready,
                    input rd_valid, input rd_data, output rd_ready);
endinterface : prspi_fifo_if

// *** rtl/prspi_fifo.sv ***
/*
 Flip-flop word buffer with valid/ready on both sides.
 Assumes an asynchronous active-low reset whose release the caller has already synchronised.
*/
`timescale 1ns/1ps

module prspi_fifo #(
   parameter int P_WIDTH = 15,
   parameter int P_DEPTH = 32
) (
   input  wire logic      i_clk,    // Core clock
   input  wire logic      i_rst_n,  // Synchronised reset, active low
   prspi_fifo_if.fifo_mp  io_q      // Push and pop sides
);
   localparam int LP_AW = $clog2(P_DEPTH);

   logic [P_WIDTH-1:0] mem_r [P_DEPTH];
   logic [LP_AW:0]     wptr_r;
   logic [LP_AW:0]     rptr_r;
   wire                empty = (wptr_r == rptr_r);
   wire                full  = (wptr_r[LP_AW] != rptr_r[LP_AW]) && (wptr_r[LP_AW-1:0] == rptr_r[LP_AW-1:0]);
   wire                push  = io_q.wr_valid && !full;
   wire                pop   = io_q.rd_ready && !empty;

   assign io_q.wr_ready = !full;
   assign io_q.rd_valid = !empty;
   assign io_q.rd_data  = mem_r[rptr_r[LP_AW-1:0]];

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         if (push) wptr_r <= wptr_r + 1'b1;
         if (pop) rptr_r <= rptr_r + 1'b1;
      end
   end

   // Storage needs no reset; a slot is only read after it was written
   always_ff @(posedge i_clk) begin
      if (push) mem_r[wptr_r[LP_AW-1:0]] <= io_q.wr_data;
   end
endmodule : prspi_fifo

// *** rtl/prspi_readout.sv ***
/*
 Serial target that streams the pressure word to an external host in clock mode zero.
 Assumes the host owns select and clock, and the sensor core offers words on a valid/ready port.
*/
`timescale 1ns/1ps
`include "prspi_defines.svh"

module prspi_readout #(
   parameter int P_EFF_BITS   = `PRSPI_EFF_BITS,   // Effective resolution in the word
   parameter int P_FIFO_DEPTH = `PRSPI_FIFO_DEPTH  // Buffered words
) (
   input  wire logic                  i_core_clk,    // Core clock, 40 MHz
   input  wire logic                  i_rstn,        // Asynchronous reset, active low
   input  wire logic                  i_spi_sck,     // Serial clock from host
   input  wire logic                  i_spi_ss_n,    // Target select, active low
   input  wire logic                  i_spi_mosi,    // Host data, ignored
   input  wire logic                  i_meas_valid,  // New measurement offered
   input  wire prspi_pkg::prspi_word_t i_meas_data,  // Measurement word
   output logic                       o_meas_ready,  // Buffer can take a word
   output logic                       o_spi_miso,    // Serial data to host
   output logic                       o_spi_miso_oe, // High while MISO is driven
   output logic                       o_selected     // Transfer in progress
);
   import prspi_pkg::*;

   localparam int          LP_WB   = `PRSPI_WORD_BITS;
   localparam int          LP_XB   = `PRSPI_XFER_BITS;
   localparam logic [3:0]  LP_HOLD = 4'(`PRSPI_HOLD_CYC);
   localparam logic [4:0]  LP_DUMMY_N = 5'(`PRSPI_DUMMY_BITS);
   localparam logic [4:0]  LP_XFER_N  = 5'(`PRSPI_XFER_BITS);

   // Reset release
   logic rst_meta_r;
   logic rst_sync_r;
   wire  rst_n = rst_sync_r;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Pin synchronisers; the previous copy is taken from the second stage only
   logic sck_meta_r;
   logic sck_sync_r;
   logic sck_prev_r;
   logic ss_meta_r;
   logic ss_sync_r;

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_meta_r <= 1'b0;
         sck_sync_r <= 1'b0;
         sck_prev_r <= 1'b0;
         ss_meta_r  <= 1'b1;
         ss_sync_r  <= 1'b1;
      end else begin
         sck_meta_r <= i_spi_sck;
         sck_sync_r <= sck_meta_r;
         sck_prev_r <= sck_sync_r;
         ss_meta_r  <= i_spi_ss_n;
         ss_sync_r  <= ss_meta_r;
      end
   end

   // Mode zero: the rising edge is the sample edge
   wire sck_rise  = sck_sync_r && !sck_prev_r;
   wire ss_active = !ss_sync_r;

   // MOSI carries no commands; the pin is deliberately left unread

   // Word buffer between the sensor core and the serial side
   prspi_fifo_if #(.P_WIDTH(LP_WB)) q_if ();

   prspi_fifo #(
      .P_WIDTH (LP_WB),
      .P_DEPTH (P_FIFO_DEPTH)
   ) u_fifo (
      .i_clk   (i_core_clk),
      .i_rst_n (rst_n),
      .io_q    (q_if.fifo_mp)
   );

   // Bits below the effective resolution are forced to zero
   wire  prspi_word_t res_mask;
   genvar gi;
   generate
      for (gi = 0; gi < LP_WB; gi++) begin : g_mask
         assign res_mask[gi] = (gi >= LP_WB - P_EFF_BITS);
      end
   endgenerate

   assign q_if.wr_valid = i_meas_valid;
   assign q_if.wr_data  = i_meas_data & res_mask;
   assign o_meas_ready  = q_if.wr_ready;

   // Serial state
   prspi_state_e state_r;
   prspi_state_e state_nxt;
   prspi_xfer_t  shreg_r;
   prspi_xfer_t  shreg_nxt;
   logic [4:0]   bits_r;
   logic [4:0]   bits_nxt;
   logic [3:0]   hold_r;
   logic [3:0]   hold_nxt;
   prspi_word_t  latest_r;
   prspi_word_t  latest_nxt;

   // While selected, the output moves only when the hold count expires after a sample edge
   wire step      = (hold_r == 4'h1);
   wire last_bit  = (bits_r == 5'h01);
   // A pop in the cycle that select drops would lose the word, so it waits for the next frame
   wire load_word = step && last_bit && (state_r != PRSPI_IDLE) && ss_active;

   // A fresh buffered word replaces the repeated one only at a word boundary,
   // so a word on the wire is never torn; with no fresh word the last one repeats
   assign q_if.rd_ready = load_word;
   wire  prspi_word_t send_word = q_if.rd_valid ? q_if.rd_data : latest_r;

   always_comb begin
      state_nxt  = state_r;
      shreg_nxt  = shreg_r;
      bits_nxt   = bits_r;
      hold_nxt   = hold_r;
      latest_nxt = latest_r;
      if (!ss_active) begin
         // Select high ends the transfer at once, whatever bit was on the wire
         state_nxt = PRSPI_IDLE;
         shreg_nxt = '1;
         bits_nxt  = LP_DUMMY_N;
         hold_nxt  = 4'h0;
      end else if (state_r == PRSPI_IDLE) begin
         // Idle already drives ones, so the dummy byte is valid at the first edge
         state_nxt = PRSPI_PREAMBLE;
         shreg_nxt = {`PRSPI_DUMMY_BYTE, 8'hFF};
         bits_nxt  = LP_DUMMY_N;
         // Select setup can be shorter than one core cycle; keep a coincident edge
         hold_nxt  = sck_rise ? LP_HOLD : 4'h0;
      end else begin
         if (sck_rise) begin
            hold_nxt = LP_HOLD;
         end else if (hold_r != 4'h0) begin
            hold_nxt = hold_r - 4'h1;
         end
         if (step) begin
            if (last_bit) begin
               state_nxt  = PRSPI_WORD;
               shreg_nxt  = {1'b0, send_word};
               bits_nxt   = LP_XFER_N;
               latest_nxt = send_word;
            end else begin
               shreg_nxt = {shreg_r[LP_XB-2:0], 1'b1};
               bits_nxt  = bits_r - 5'h01;
            end
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r  <= PRSPI_IDLE;
         shreg_r  <= '1;
         bits_r   <= 5'(`PRSPI_DUMMY_BITS);
         hold_r   <= 4'h0;
         latest_r <= '0;
      end else begin
         state_r  <= state_nxt;
         shreg_r  <= shreg_nxt;
         bits_r   <= bits_nxt;
         hold_r   <= hold_nxt;
         latest_r <= latest_nxt;
      end
   end

   // MSB of the shift register is the wire; ones outside a transfer
   assign o_spi_miso    = shreg_r[LP_XB-1];
   assign o_spi_miso_oe = (state_r != PRSPI_IDLE);
   assign o_selected    = (state_r != PRSPI_IDLE);
endmodule : prspi_readout

// *** verification/prspi_readout_properties.sv ***
/* Checker for the pressure readout target.
 Assumes link pins are sampled by the core clock. */
`timescale 1ns/1ps
module prspi_readout_properties (
   input wire logic i_core_clk,    // Core clock
   input wire logic i_rstn,        // Reset, active low
   input wire logic i_spi_sck,     // Serial clock
   input wire logic i_spi_ss_n,    // Select, active low
   input wire logic i_meas_valid,  // Word offered
   input wire logic o_meas_ready,  // Buffer not full
   input wire logic o_spi_miso,    // Serial data
   input wire logic o_spi_miso_oe, // Data driven
   input wire logic o_selected     // Transfer active
);
   logic       sck_d_r;
   logic [3:0] since_rise_r;
   wire        sck_rise = i_spi_sck && !sck_d_r;
   wire  [3:0] since_nxt = sck_rise ? 4'h0 : (since_rise_r == 4'hF ? 4'hF : since_rise_r + 4'h1);
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sck_d_r      <= 1'b0;
         since_rise_r <= 4'hF;
      end else begin
         sck_d_r      <= i_spi_sck;
         since_rise_r <= since_nxt;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);
   sequence s_sel_held;
      !i_spi_ss_n [*5];
   endsequence
   sequence s_desel_held;
      i_spi_ss_n [*5];
   endsequence
   a_select_drives: assert property (s_sel_held |-> o_selected && o_spi_miso_oe)
      else $error("select held but target idle");
   a_deselect_ends: assert property (s_desel_held |-> !o_selected && !o_spi_miso_oe)
      else $error("deselected but still driving");
   a_idle_miso_high: assert property (!o_spi_miso_oe |-> o_spi_miso)
      else $error("idle miso low");
   a_dummy_starts_high: assert property ($rose(o_selected) |-> o_spi_miso)
      else $error("first bit not one");
   a_miso_hold: assert property ($rose(i_spi_sck) && !i_spi_ss_n |=> (i_spi_ss_n || $stable(o_spi_miso)) [*8])
      else $error("miso moved too soon");
   a_miso_change_slot: assert property ($changed(o_spi_miso) && o_selected && $past(o_selected)
      |-> since_rise_r inside {[4'h7:4'hC]}) else $error("miso moved off slot");
   a_ready_falls_push: assert property ($fell(o_meas_ready) |-> $past(i_meas_valid))
      else $error("ready fell without push");
   a_pop_in_transfer: assert property ($rose(o_meas_ready) && $past(i_rstn, 3) |-> $past(o_selected))
      else $error("pop outside transfer");
endmodule : prspi_readout_properties
bind prspi_readout prspi_readout_properties u_prspi_readout_properties (.i_core_clk, .i_rstn, .i_spi_sck,
   .i_spi_ss_n, .i_meas_valid, .o_meas_ready, .o_spi_miso, .o_spi_miso_oe, .o_selected);

// *** verification/prspi_host_model.sv ***
/* SPI host model in clock mode zero.
 Assumes the bench calls frame() with select idle. */
`timescale 1ns/1ps
module prspi_host_model (
   input  wire logic i_miso, // Target data
   output logic      o_sck,  // Serial clock
   output logic      o_ss_n, // Select, active low
   output logic      o_mosi  // Host data
);
   localparam int HALF = 800; // 625 kHz
   logic rx_q[$];
   initial begin
      o_sck  = 1'b0;
      o_ss_n = 1'b1;
      o_mosi = 1'b1;
   end
   task automatic frame(input int nbits, input bit junk);
      o_ss_n = 1'b0;
      #HALF;
      for (int i = 0; i < nbits; i++) begin
         o_mosi = junk ? 1'($urandom) : 1'b1;
         #HALF;
         o_sck = 1'b1;
         rx_q.push_back(i_miso);
         #HALF;
         o_sck = 1'b0;
      end
      #100;
      o_ss_n = 1'b1;
      o_mosi = 1'b1;
      // Idle gap so back-to-back frames show the target a clean deselect
      #(2 * HALF);
   endtask : frame
endmodule : prspi_host_model

// *** verification/tb_top.sv ***
/* Self-checking bench for the pressure readout target.
 Assumes host model and checker are compiled first. */
`timescale 1ns/1ps
module tb_top;
   import prspi_pkg::*;
   localparam int EFF = 12;
   localparam int OUT_MIN = 1638;
   localparam int OUT_MAX = 27852;
   localparam int P_MIN = -100;
   localparam int P_MAX = 100;
   localparam int DEPTH = 32;
   localparam prspi_word_t MASK = prspi_word_t'(16'h7FFF << (15 - EFF));
   logic clk, rstn, valid, ready, miso, oe, sel, sck, ss_n, mosi;
   prspi_word_t data;
   prspi_word_t last_w = '0;
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int pushed;
   int exp_q[$];
   logic exp_bits[$];
   prspi_readout #(.P_EFF_BITS(EFF), .P_FIFO_DEPTH(DEPTH)) u_prspi_readout (.i_core_clk(clk), .i_rstn(rstn),
      .i_spi_sck(sck), .i_spi_ss_n(ss_n), .i_spi_mosi(mosi), .i_meas_valid(valid), .i_meas_data(data),
      .o_meas_ready(ready), .o_spi_miso(miso), .o_spi_miso_oe(oe), .o_selected(sel));
   prspi_host_model u_prspi_host_model (.i_miso(miso), .o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         conclude();
      end
   end
   task automatic check(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : check
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : check_word
   task automatic check_mbar(input logic signed [31:0] got, input logic signed [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : check_mbar
   // Host's linear conversion, in hundredths of a mbar
   function automatic logic signed [31:0] to_mbar(input logic [15:0] counts);
      return ((signed'({16'h0000, counts}) - OUT_MIN) * (P_MAX - P_MIN) * 100) / (OUT_MAX - OUT_MIN) + P_MIN * 100;
   endfunction : to_mbar
   task automatic read(input int words, input bit junk);
      int          exp_w[$];
      logic        got_b;
      logic [7:0]  byte_b;
      logic [7:0]  hi_b;
      logic [15:0] got_w;
      logic [15:0] want_w;
      for (int i = 0; i < 8; i++) exp_bits.push_back(1'b1);
      for (int i = 0; i < words; i++) begin
         if (exp_q.size() > 0) last_w = prspi_word_t'(exp_q.pop_front());
         exp_w.push_back(int'(last_w));
         exp_bits.push_back(1'b0);
         for (int b = 14; b >= 0; b--) exp_bits.push_back(last_w[b]);
      end
      u_prspi_host_model.frame(8 + 16 * words, junk);
      byte_b = '0;
      hi_b = '0;
      // The first byte is checked bit by bit against ones but never assembled into a word
      for (int n = 0; n < 8 + 16 * words; n++) begin
         got_b = u_prspi_host_model.rx_q.pop_front();
         check(got_b, exp_bits.pop_front(), "bit");
         byte_b = {byte_b[6:0], got_b};
         if (n % 16 == 15) hi_b = byte_b;
         else if (n % 16 == 7 && n > 7) begin
            got_w = (16'(hi_b) << 8) | 16'(byte_b);
            want_w = {1'b0, prspi_word_t'(exp_w.pop_front())};
            check_word(got_w, want_w, "word");
            check_mbar(to_mbar(got_w), to_mbar(want_w), "pressure");
         end
      end
   endtask : read
   task automatic conclude;
      $display("checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   initial begin
      rstn = 1'b0;
      valid = 1'b0;
      data = '0;
      void'($urandom(65));
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      check(miso, 1'b1, "idle miso");
      check(oe, 1'b0, "idle oe");
      u_prspi_host_model.frame(4, 1'b0);
      repeat (5) @(negedge clk);
      check(oe | sel | ~miso, 1'b0, "abort");
      repeat (4) check(u_prspi_host_model.rx_q.pop_front(), 1'b1, "abort bit");
      read(2, 1'b0);
      pushed = 0;
      @(negedge clk);
      while (ready === 1'b1 && pushed < DEPTH + 8) begin
         valid = 1'b1;
         data = prspi_word_t'($urandom);
         exp_q.push_back(data & MASK);
         @(negedge clk);
         pushed++;
      end
      check(logic'(pushed == DEPTH), 1'b1, "fill depth");
      data = prspi_word_t'($urandom);
      repeat (10) @(negedge clk);
      valid = 1'b0;
      read(DEPTH + 1, 1'b1);
      check(ready, 1'b1, "drained");
      read(1, 1'b0);
      conclude();
   end
endmodule : tb_top
